// ===== bench/drc_ctrl_sva.sv
`default_nettype none
module drc_ctrl_sva #(
   parameter [15:0] REF_TICK_CYC = 16'h0138,
   parameter [15:0] PAGE_MAX_CYC = 16'h0258
) (
   input wire clk,
   input wire rst_n,
   input wire row_strobe_n,
   input wire col_strobe_n,
   input wire store_select_n,
   input wire drive_on_n,
   input wire io_lines_oe,
   input wire rd_valid,
   input wire [7:0] mux_addr_bus
);
   logic [15:0] hi_cnt, lo_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always @(posedge clk) begin
      hi_cnt <= (!rst_n || !row_strobe_n) ? 16'h0000 : hi_cnt + 16'h0001;
      lo_cnt <= (!rst_n || row_strobe_n) ? 16'h0000 : lo_cnt + 16'h0001;
   end
   a_row_addr: assert property ($fell(row_strobe_n) |-> $stable(mux_addr_bus))
      else $error("row address moved at strobe");
   a_col_addr: assert property ($fell(col_strobe_n) |-> $stable(mux_addr_bus) && !mux_addr_bus[7] && !mux_addr_bus[0])
      else $error("column address bad at strobe");
   a_col_in_row: assert property ($fell(col_strobe_n) |-> !row_strobe_n)
      else $error("column strobe without open row");
   a_bus_release: assert property (io_lines_oe |-> drive_on_n)
      else $error("data driven while outputs enabled");
   a_ras_width: assert property ($fell(row_strobe_n) |-> (!row_strobe_n)[*3])
      else $error("row strobe pulse too short");
   a_precharge: assert property ($rose(row_strobe_n) |-> (row_strobe_n)[*2])
      else $error("precharge too short");
   // Margin covers the access that runs out after the last page hit
   a_page_limit: assert property (lo_cnt <= PAGE_MAX_CYC + 16'h000c)
      else $error("row held open too long");
   a_refresh_gap: assert property (hi_cnt <= REF_TICK_CYC + 16'h0010)
      else $error("refresh overdue");
   c_read: cover property (rd_valid);
   c_hidden: cover property ($fell(row_strobe_n) && !col_strobe_n);
   c_late_write: cover property ($fell(store_select_n) && !col_strobe_n);
endmodule
`default_nettype wire

// ===== bench/drc_ctrl_tb.sv
`default_nettype none
module drc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, req_valid, req_write, req_rmw, req_hidden_ref;
   logic [13:0] req_addr;
   logic [3:0] req_wdata;
   wire req_ready, rd_valid, row_strobe_n, col_strobe_n, store_select_n, drive_on_n, io_lines_oe;
   wire [3:0] rd_data, io_lines_o, io_lines_i;
   wire [7:0] mux_addr_bus;
   int n_mismatch, checks_done, n_ref, n_hid;
   drc_ctrl #(.REF_TICK_CYC(16'h0028), .PAGE_MAX_CYC(16'h0014)) i_drc_ctrl (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw),
      .req_hidden_ref(req_hidden_ref), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
      .rd_data(rd_data), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
      .store_select_n(store_select_n), .drive_on_n(drive_on_n), .mux_addr_bus(mux_addr_bus),
      .io_lines_o(io_lines_o), .io_lines_oe(io_lines_oe), .io_lines_i(io_lines_i));
   drc_mem_model i_drc_mem_model (.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
      .store_select_n(store_select_n), .drive_on_n(drive_on_n), .mux_addr_bus(mux_addr_bus),
      .io_lines_o(io_lines_o), .io_lines_oe(io_lines_oe), .io_lines_i(io_lines_i));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge row_strobe_n) begin
      if (rst_n === 1'b1 && col_strobe_n === 1'b1) n_ref++;
      if (rst_n === 1'b1 && col_strobe_n === 1'b0) n_hid++;
   end
   task close_out;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [3:0] e, input logic [3:0] s);
      checks_done++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   task xfer(input logic w, m, h, input logic [13:0] a, input logic [3:0] d, e);
      int i;
      req_write = w;
      req_rmw = m;
      req_hidden_ref = h;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
      if (req_ready !== 1'b1) begin
         n_mismatch++;
         close_out;
      end
      @(negedge clk);
      req_valid = 1'b0;
      // Let an edge pass so a following call does not raise valid in this step
      if (w)
         @(negedge clk);
      if (!w) begin
         for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge clk);
         if (rd_valid !== 1'b1) begin
            n_mismatch++;
            close_out;
         end
         chk("rd_data", e, rd_data);
      end
   endtask
   logic [13:0] adr [4] = '{14'h0000, 14'h3fff, 14'h2a55, 14'h2a41};
   task t_rw;
      for (int k = 0; k < 4; k++) xfer(1'b1, 1'b0, 1'b0, adr[k], 4'h5 + 4'(k), 4'h0);
      // Reads carry inverted write data, which must not reach storage
      for (int k = 0; k < 4; k++) xfer(1'b0, 1'b0, 1'b0, adr[k], 4'ha - 4'(k), 4'h5 + 4'(k));
      $display("test rw done");
   endtask
   task t_rmw;
      xfer(1'b0, 1'b1, 1'b0, adr[1], 4'h9, 4'h6);
      xfer(1'b0, 1'b0, 1'b0, adr[1], 4'h0, 4'h9);
      $display("test rmw done");
   endtask
   task t_page;
      int i, r;
      r = n_ref;
      // Start right after a refresh so no tick can break the open page
      for (i = 0; i < 100 && n_ref == r; i++) @(negedge clk);
      req_write = 1'b0;
      req_rmw = 1'b0;
      req_hidden_ref = 1'b0;
      req_wdata = 4'h0;
      req_addr = adr[2];
      req_valid = 1'b1;
      for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      // Second column of the same row is offered while the first is open
      req_addr = adr[3];
      for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clk);
      if (req_ready !== 1'b1) begin
         n_mismatch++;
         close_out;
      end
      r = n_ref;
      @(negedge clk);
      req_valid = 1'b0;
      chk("rd_valid", 4'h1, {3'h0, rd_valid});
      chk("rd_data", 4'h7, rd_data);
      @(negedge clk);
      for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge clk);
      if (rd_valid !== 1'b1) begin
         n_mismatch++;
         close_out;
      end
      chk("rd_data", 4'h8, rd_data);
      chk("page row", 4'h0, {3'h0, n_ref != r});
      $display("test page done");
   endtask
   task t_hidden;
      int h0;
      h0 = n_hid;
      xfer(1'b0, 1'b0, 1'b1, adr[0], 4'h0, 4'h5);
      repeat (30) @(negedge clk);
      chk("hidden", 4'h1, {3'h0, n_hid > h0});
      $display("test hidden done");
   endtask
   task t_refresh;
      n_ref = 0;
      repeat (200) @(negedge clk);
      chk("refresh", 4'h1, {3'h0, n_ref >= 4});
      xfer(1'b0, 1'b0, 1'b0, adr[1], 4'h0, 4'h9);
      $display("test refresh done");
   endtask
   initial begin
      {rst_n, req_valid, req_write, req_rmw, req_hidden_ref, req_addr, req_wdata} = '0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_rw();
      t_rmw();
      t_page();
      t_hidden();
      t_refresh();
      close_out();
   end
endmodule
bind drc_ctrl drc_ctrl_sva #(.REF_TICK_CYC(REF_TICK_CYC), .PAGE_MAX_CYC(PAGE_MAX_CYC)) i_drc_ctrl_sva (.clk(clk),
   .rst_n(rst_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .store_select_n(store_select_n),
   .drive_on_n(drive_on_n), .io_lines_oe(io_lines_oe), .rd_valid(rd_valid), .mux_addr_bus(mux_addr_bus));
`default_nettype wire

// ===== bench/drc_mem_model.sv
`default_nettype none
module drc_mem_model (
   input wire row_strobe_n,
   input wire col_strobe_n,
   input wire store_select_n,
   input wire drive_on_n,
   input wire [7:0] mux_addr_bus,
   input wire [3:0] io_lines_o,
   input wire io_lines_oe,
   output wire [3:0] io_lines_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] mem [0:16383];
   logic [7:0] row;
   logic [5:0] col;
   logic [3:0] q = 4'h5;
   logic early = 1'b0;
   logic on = 1'b0;
   always @(negedge row_strobe_n) row = mux_addr_bus;
   always @(negedge col_strobe_n) begin
      col = mux_addr_bus[6:1];
      early = !store_select_n;
      if (early) mem[{row, col}] = io_lines_i;
      else q = mem[{row, col}];
   end
   always @(negedge store_select_n)
      if (!col_strobe_n) mem[{row, col}] = io_lines_i;
   always @*
      if (drive_on_n || col_strobe_n || early) on = 1'b0;
      else if (!row_strobe_n) on = 1'b1;
   // No pull-up on the lines: a released bus shows the inverse, clashes show unknown
   assign io_lines_i = io_lines_oe ? (on ? 4'hx : io_lines_o) : (on ? q : ~q);
endmodule
`default_nettype wire

// ===== hdl/drc_ctrl.v
`default_nettype none
`include "drc_map.vh"
module drc_ctrl #(
   parameter [`DRC_CNT_W-1:0] REF_TICK_CYC = 16'h0138,
   parameter [`DRC_CNT_W-1:0] PAGE_MAX_CYC = 16'h0258
) (
   input wire clk,
   input wire rst_n,
   input wire req_valid,
   output wire req_ready,
   input wire req_write,
   input wire req_rmw,
   input wire req_hidden_ref,
   input wire [`DRC_ADDR_W-1:0] req_addr,
   input wire [`DRC_DATA_W-1:0] req_wdata,
   output reg rd_valid,
   output reg [`DRC_DATA_W-1:0] rd_data,
   output reg row_strobe_n,
   output reg col_strobe_n,
   output reg store_select_n,
   output reg drive_on_n,
   output reg [`DRC_ROW_W-1:0] mux_addr_bus,
   output reg [`DRC_DATA_W-1:0] io_lines_o,
   output reg io_lines_oe,
   input wire [`DRC_DATA_W-1:0] io_lines_i
);
   function [`DRC_CNT_W-1:0] cyc_min;
      input integer ns;
      integer full;
      begin
         full = (ns + `DRC_CLK_NS - 1) / `DRC_CLK_NS;
         cyc_min = full[`DRC_CNT_W-1:0];
      end
   endfunction
   localparam [`DRC_CNT_W-1:0] C_RCD = cyc_min(`DRC_T_RCD_NS);
   localparam [`DRC_CNT_W-1:0] C_CAS = cyc_min(`DRC_T_ACCESS_NS);
   localparam [`DRC_CNT_W-1:0] C_WP = cyc_min(`DRC_T_WP_NS);
   localparam [`DRC_CNT_W-1:0] C_PRE = cyc_min(`DRC_T_CYCLE_NS - `DRC_T_ACCESS_NS);
   localparam [8:0] S_IDLE = 9'h001, S_ROW = 9'h002, S_COL = 9'h004, S_ACC = 9'h008,
      S_WDEL = 9'h010, S_WLOW = 9'h020, S_PRE = 9'h040, S_REF = 9'h080, S_HID = 9'h100;
   reg [8:0] state_reg;
   reg [`DRC_CNT_W-1:0] cnt_reg;
   reg [`DRC_CNT_W-1:0] page_reg;
   reg [`DRC_REF_ROW_W-1:0] ref_row_reg;
   reg [`DRC_ROW_W-1:0] open_row_reg;
   reg ref_pend_reg;
   reg hid_reg;
   reg wr_reg;
   reg rmw_reg;
   reg [`DRC_COL_W-1:0] col_reg;
   reg [`DRC_DATA_W-1:0] wdata_reg;
   reg [`DRC_DATA_W-1:0] sync1_reg;
   reg [`DRC_DATA_W-1:0] sync2_reg;
   wire ref_tick;
   wire [`DRC_ROW_W-1:0] req_row = req_addr[`DRC_ADDR_W-1:`DRC_COL_W];
   wire cnt_done = (cnt_reg == `DRC_ZERO_16);
   // Page hit reuses the open row unless refresh or the page limit intervene; a read-modify-write in progress still raises it
   wire page_ok = (state_reg == S_ACC) && cnt_done && req_valid && !ref_pend_reg &&
      (req_row == open_row_reg) && (page_reg < PAGE_MAX_CYC);
   assign req_ready = ((state_reg == S_IDLE) && !ref_pend_reg) || page_ok;
   drc_tick #(.PERIOD(REF_TICK_CYC)) u_tick (.clk(clk), .rst_n(rst_n), .tick(ref_tick));
   always @(posedge clk) begin
      sync1_reg <= io_lines_i;
      sync2_reg <= sync1_reg;
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         cnt_reg <= `DRC_ZERO_16;
         page_reg <= `DRC_ZERO_16;
         ref_row_reg <= {`DRC_REF_ROW_W{1'b0}};
         open_row_reg <= {`DRC_ROW_W{1'b0}};
         ref_pend_reg <= 1'b0;
         hid_reg <= 1'b0;
         wr_reg <= 1'b0;
         rmw_reg <= 1'b0;
         col_reg <= {`DRC_COL_W{1'b0}};
         wdata_reg <= {`DRC_DATA_W{1'b0}};
         rd_valid <= 1'b0;
         rd_data <= {`DRC_DATA_W{1'b0}};
         row_strobe_n <= 1'b1;
         col_strobe_n <= 1'b1;
         store_select_n <= 1'b1;
         drive_on_n <= 1'b1;
         mux_addr_bus <= {`DRC_ROW_W{1'b0}};
         io_lines_o <= {`DRC_DATA_W{1'b0}};
         io_lines_oe <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         // Tick sets the pending flag; setting beats the clear below
         if (ref_tick)
            ref_pend_reg <= 1'b1;
         if (!row_strobe_n)
            page_reg <= page_reg + `DRC_ONE_16;
         else
            page_reg <= `DRC_ZERO_16;
         if (!cnt_done)
            cnt_reg <= cnt_reg - `DRC_ONE_16;
         case (state_reg)
            S_IDLE: begin
               // Standby: both strobes high, bus released
               if (ref_pend_reg) begin
                  mux_addr_bus <= {1'b0, ref_row_reg};
                  state_reg <= S_REF;
                  cnt_reg <= C_CAS;
               end else if (req_valid) begin
                  mux_addr_bus <= req_row;
                  open_row_reg <= req_row;
                  col_reg <= req_addr[`DRC_COL_W-1:0];
                  wr_reg <= req_write;
                  rmw_reg <= req_rmw;
                  hid_reg <= req_hidden_ref;
                  wdata_reg <= req_wdata;
                  state_reg <= S_ROW;
               end
            end
            S_ROW: begin
               row_strobe_n <= 1'b0;
               state_reg <= S_COL;
               cnt_reg <= C_RCD;
            end
            S_COL: begin
               if (cnt_done) begin
                  // Column sits on lines 1..6, line 0 and 7 idle
                  mux_addr_bus <= {1'b0, col_reg, 1'b0};
                  if (wr_reg && !rmw_reg) begin
                     store_select_n <= 1'b0;
                     io_lines_o <= wdata_reg;
                     io_lines_oe <= 1'b1;
                     drive_on_n <= 1'b1;
                  end else begin
                     store_select_n <= 1'b1;
                     drive_on_n <= 1'b0;
                     io_lines_oe <= 1'b0;
                  end
                  state_reg <= S_ACC;
                  cnt_reg <= C_CAS;
               end
            end
            S_ACC: begin
               if (col_strobe_n && !cnt_done) begin
                  col_strobe_n <= 1'b0;
               end else if (cnt_done) begin
                  if (!wr_reg || rmw_reg) begin
                     rd_data <= sync2_reg;
                     rd_valid <= !wr_reg;
                  end
                  if (rmw_reg) begin
                     drive_on_n <= 1'b1;
                     state_reg <= S_WDEL;
                  end else if (page_ok) begin
                     col_strobe_n <= 1'b1;
                     io_lines_oe <= 1'b0;
                     store_select_n <= 1'b1;
                     col_reg <= req_addr[`DRC_COL_W-1:0];
                     wr_reg <= req_write;
                     rmw_reg <= req_rmw;
                     wdata_reg <= req_wdata;
                     state_reg <= S_COL;
                     cnt_reg <= C_RCD;
                  end else if (hid_reg && !wr_reg) begin
                     row_strobe_n <= 1'b1;
                     mux_addr_bus <= {1'b0, ref_row_reg};
                     state_reg <= S_HID;
                     cnt_reg <= C_PRE;
                  end else begin
                     state_reg <= S_PRE;
                  end
               end
            end
            S_WDEL: begin
               // Bus released; data goes out a cycle before store select for setup
               io_lines_o <= wdata_reg;
               io_lines_oe <= 1'b1;
               state_reg <= S_WLOW;
               cnt_reg <= C_WP;
            end
            S_WLOW: begin
               store_select_n <= 1'b0;
               if (cnt_done && !store_select_n)
                  state_reg <= S_PRE;
            end
            S_PRE: begin
               row_strobe_n <= 1'b1;
               col_strobe_n <= 1'b1;
               store_select_n <= 1'b1;
               drive_on_n <= 1'b1;
               io_lines_oe <= 1'b0;
               state_reg <= S_IDLE;
               cnt_reg <= C_PRE;
            end
            S_REF: begin
               // Row-only refresh: column strobe stays high
               row_strobe_n <= 1'b0;
               if (!row_strobe_n && cnt_done) begin
                  ref_row_reg <= ref_row_reg + 1'b1;
                  if (!ref_tick)
                     ref_pend_reg <= 1'b0;
                  state_reg <= S_PRE;
               end
            end
            S_HID: begin
               // Column strobe and output enable held, data stays valid
               if (cnt_done && row_strobe_n) begin
                  row_strobe_n <= 1'b0;
                  cnt_reg <= C_CAS;
               end else if (cnt_done) begin
                  ref_row_reg <= ref_row_reg + 1'b1;
                  if (!ref_tick)
                     ref_pend_reg <= 1'b0;
                  state_reg <= S_PRE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== hdl/drc_map.vh
`ifndef DRC_MAP_VH
`define DRC_MAP_VH
// Organisation: 14-bit address split into an 8-bit row and a 6-bit column
`define DRC_ADDR_W 14
`define DRC_ROW_W 8
`define DRC_COL_W 6
`define DRC_DATA_W 4
`define DRC_COL_LSB 1
// Clock period in ns at 20 MHz
`define DRC_CLK_NS 50
// Timing figures in ns, fast grade
`define DRC_T_ACCESS_NS 120
`define DRC_T_CYCLE_NS 220
`define DRC_T_PRECHARGE_NS 90
`define DRC_T_RCD_NS 25
`define DRC_T_CAS_NS 60
`define DRC_T_WP_NS 40
// Refresh: 128 rows every 2 ms, page mode 30 us maximum
`define DRC_REF_ROWS 128
`define DRC_REF_PERIOD_NS 2000000
`define DRC_PAGE_MAX_NS 30000
`define DRC_REF_ROW_W 7
`define DRC_CNT_W 16
`define DRC_ONE_16 16'h0001
`define DRC_ZERO_16 16'h0000
`endif

// ===== hdl/drc_tick.v
`default_nettype none
`include "drc_map.vh"
// Free-running refresh interval tick: a pulse every period cycles
module drc_tick #(
   parameter [`DRC_CNT_W-1:0] PERIOD = 16'h0138
) (
   input wire clk,
   input wire rst_n,
   output reg tick
);
   reg [`DRC_CNT_W-1:0] cnt_reg;
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= `DRC_ZERO_16;
         tick <= 1'b0;
      end else if (cnt_reg >= PERIOD - `DRC_ONE_16) begin
         cnt_reg <= `DRC_ZERO_16;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + `DRC_ONE_16;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire
